// ==== src/aprl_regs.vh ====
// constants for the absolute position restore link
// Notes on behaviour
// - three inputs, three outputs, dedicated, fixed order
// - pulses within plus/minus 32768 revolutions window
// - positioning address within signed 32 bits; checked against the same 32768-revolution window as the pulses
// - servo enable drops about 20 ms
// - no endless one-direction feed when absolute
`ifndef APRL_REGS_VH
`define APRL_REGS_VH
`define APRL_WORD_W      32
`define APRL_STEPS       6'h10
`define APRL_STEP_W      6
`define APRL_SERVO_DROP_MS 20
`define APRL_CLK_KHZ     10000
`define APRL_DROP_CYC    (`APRL_SERVO_DROP_MS * `APRL_CLK_KHZ)
`define APRL_REV_MULT    32768
`define APRL_TMO_W       24
`endif

// ==== src/aprl_restore_link.v ====
// absolute position restore link: handshake, assembly, range checks
`timescale 1ns/1ps
`include "aprl_regs.vh"
module aprl_restore_link #(
	parameter DROP_CYC = `APRL_DROP_CYC      // servo-off window in cycles
) (
	input  wire        I_CORE_CLK,          // core clock 10 MHz
	input  wire        I_NRST,              // sync reset, active low
	input  wire        I_START,             // pulse: begin restoration
	input  wire [31:0] I_FB_PULSES,         // feedback pulses per revolution
	input  wire [31:0] I_TARGET_ADDR,       // signed positioning address to check
	input  wire [31:0] I_OUT_PULSES,        // signed pulses output from origin
	input  wire        I_CONT_FEED,         // request for endless one-way feed
	input  wire        I_ABS_DATA_LOW_BIT,  // servo data line bit 0 (pin)
	input  wire        I_ABS_DATA_HIGH_BIT, // servo data line bit 1 (pin)
	input  wire        I_ABS_DATA_READY_LINE, // servo data ready (pin)
	input  wire        I_RD_READY,          // consumer ready for position word
	output reg         O_SERVO_ENABLE_LINE, // servo on output
	output reg         O_ABS_TRANSFER_MODE_LINE, // transfer mode output
	output reg         O_ABS_REQUEST_LINE,  // request output
	output reg         O_BUSY,              // restoration in progress
	output reg         O_RESTORED,          // restored since reset
	output reg         O_RANGE_ERR,         // pulses or address out of range
	output reg         O_FEED_REJECT,       // endless feed refused
	output reg         O_RD_VALID,          // position word valid
	output reg  [31:0] O_RD_DATA            // assembled position word
);
	// ----------------------------------------------------------------
	// input synchronisers, three stages, change when stage 2 and 3 agree
	// ----------------------------------------------------------------
	reg [2:0] s_lo;
	reg [2:0] s_hi;
	reg [2:0] s_rdy;
	reg       f_lo;
	reg       f_hi;
	reg       f_rdy;
	always @(posedge I_CORE_CLK) begin
		if (!I_NRST) begin
			s_lo  <= 3'h0;
			s_hi  <= 3'h0;
			s_rdy <= 3'h0;
			f_lo  <= 1'b0;
			f_hi  <= 1'b0;
			f_rdy <= 1'b0;
		end else begin
			s_lo  <= {s_lo[1:0], I_ABS_DATA_LOW_BIT};
			s_hi  <= {s_hi[1:0], I_ABS_DATA_HIGH_BIT};
			s_rdy <= {s_rdy[1:0], I_ABS_DATA_READY_LINE};
			if (s_lo[1] == s_lo[2])
				f_lo <= s_lo[2];
			if (s_hi[1] == s_hi[2])
				f_hi <= s_hi[2];
			if (s_rdy[1] == s_rdy[2])
				f_rdy <= s_rdy[2];
		end
	end

	// ----------------------------------------------------------------
	// range checks
	// ----------------------------------------------------------------
	// one window test shared by the pulse count and the address
	function out_of_window;
		input signed [63:0] val;
		input signed [63:0] lo;
		input signed [63:0] hi;
		begin
			out_of_window = (val > hi) || (val < lo);
		end
	endfunction

	// address and pulses both sign-extended to 64 bits and checked against the same window
	wire signed [63:0] lim_hi = $signed({32'h0, I_FB_PULSES}) * `APRL_REV_MULT - 64'sh1;
	wire signed [63:0] lim_lo = -($signed({32'h0, I_FB_PULSES}) * `APRL_REV_MULT);
	wire signed [63:0] pulses = {{32{I_OUT_PULSES[31]}}, I_OUT_PULSES};
	wire signed [63:0] addr   = {{32{I_TARGET_ADDR[31]}}, I_TARGET_ADDR};
	wire               bad    = out_of_window(pulses, lim_lo, lim_hi) || out_of_window(addr, lim_lo, lim_hi);

	// ----------------------------------------------------------------
	// two-entry output buffer
	// ----------------------------------------------------------------
	reg  [31:0] buf0;
	reg  [31:0] buf1;
	reg  [1:0]  cnt;
	wire        buf_ready = (cnt != 2'h2);
	reg         push;
	reg  [31:0] push_data;
	wire        pop = O_RD_VALID && I_RD_READY;
	reg  [31:0] next_buf0;
	reg  [31:0] next_buf1;
	reg  [1:0]  next_cnt;

	// ----------------------------------------------------------------
	// handshake state machine
	// ----------------------------------------------------------------
	localparam ST_IDLE = 5'h01;
	localparam ST_DROP = 5'h02;
	localparam ST_REQ  = 5'h04;
	localparam ST_REL  = 5'h08;
	localparam ST_PUSH = 5'h10;
	reg [4:0]               state;
	reg [`APRL_STEP_W-1:0]  step;
	reg [31:0]              acc;
	reg [`APRL_TMO_W-1:0]   tmr;

	always @(posedge I_CORE_CLK) begin
		if (!I_NRST) begin
			state                    <= ST_IDLE;
			step                     <= 6'h00;
			acc                      <= 32'h0;
			tmr                      <= 24'h0;
			push                     <= 1'b0;
			push_data                <= 32'h0;
			O_SERVO_ENABLE_LINE      <= 1'b0;
			O_ABS_TRANSFER_MODE_LINE <= 1'b0;
			O_ABS_REQUEST_LINE       <= 1'b0;
			O_BUSY                   <= 1'b0;
			O_RESTORED               <= 1'b0;
			O_RANGE_ERR              <= 1'b0;
			O_FEED_REJECT            <= 1'b0;
		end else begin
			push          <= 1'b0;
			O_RANGE_ERR   <= bad;
			O_FEED_REJECT <= I_CONT_FEED;
			case (state)
			ST_IDLE: begin
				O_SERVO_ENABLE_LINE <= 1'b1;
				if (I_START && !bad) begin
					O_SERVO_ENABLE_LINE <= 1'b0;
					O_BUSY              <= 1'b1;
					tmr                 <= DROP_CYC[`APRL_TMO_W-1:0];
					state               <= ST_DROP;
				end
			end
			ST_DROP: begin
				// servo off window; brake recommended externally
				if (tmr == 24'h0) begin
					O_SERVO_ENABLE_LINE      <= 1'b1;
					O_ABS_TRANSFER_MODE_LINE <= 1'b1;
					O_ABS_REQUEST_LINE       <= 1'b1;
					step                     <= 6'h00;
					acc                      <= 32'h0;
					state                    <= ST_REQ;
				end else
					tmr <= tmr - 24'h1;
			end
			ST_REQ: begin
				if (f_rdy) begin
					acc                <= {f_hi, f_lo, acc[31:2]};
					O_ABS_REQUEST_LINE <= 1'b0;
					step               <= step + 6'h01;
					state              <= ST_REL;
				end
			end
			ST_REL: begin
				// wait for ready to fall before the next step
				if (!f_rdy) begin
					if (step == `APRL_STEPS)
						state <= ST_PUSH;
					else begin
						O_ABS_REQUEST_LINE <= 1'b1;
						state              <= ST_REQ;
					end
				end
			end
			ST_PUSH: begin
				if (buf_ready) begin
					push                     <= 1'b1;
					push_data                <= acc;
					O_ABS_TRANSFER_MODE_LINE <= 1'b0;
					O_BUSY                   <= 1'b0;
					O_RESTORED               <= 1'b1;
					state                    <= ST_IDLE;
				end
			end
			default: state <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// buffer next state; the head word always sits in buf0
	// ----------------------------------------------------------------
	always @* begin
		next_buf0 = buf0;
		next_buf1 = buf1;
		next_cnt  = cnt;
		case ({push, pop})
		2'b10: begin
			if (cnt == 2'h0)
				next_buf0 = push_data;
			else
				next_buf1 = push_data;
			next_cnt = cnt + 2'h1;
		end
		2'b01: begin
			next_buf0 = buf1;
			next_cnt  = cnt - 2'h1;
		end
		2'b11: begin
			// count stays; the pushed word takes the freed place
			if (cnt == 2'h1)
				next_buf0 = push_data;
			else begin
				next_buf0 = buf1;
				next_buf1 = push_data;
			end
		end
		default: next_cnt = cnt;
		endcase
	end

	// outputs copy the next head so valid and data always move together
	always @(posedge I_CORE_CLK) begin
		if (!I_NRST) begin
			buf0       <= 32'h0;
			buf1       <= 32'h0;
			cnt        <= 2'h0;
			O_RD_VALID <= 1'b0;
			O_RD_DATA  <= 32'h0;
		end else begin
			buf0       <= next_buf0;
			buf1       <= next_buf1;
			cnt        <= next_cnt;
			O_RD_VALID <= (next_cnt != 2'h0);
			O_RD_DATA  <= next_buf0;
		end
	end
endmodule

// ==== dv/aprl_restore_link_props.sv ====
// port checker for the restore link
`timescale 1ns/1ps
module aprl_restore_link_props #(parameter int DROP_CYC = 5) (
	input wire logic        I_CORE_CLK,               // core clock
	input wire logic        I_NRST,                   // sync reset, active low
	input wire logic        I_START,                  // start pulse
	input wire logic        I_CONT_FEED,              // endless feed request
	input wire logic        I_ABS_DATA_READY_LINE,    // servo ready pin
	input wire logic        I_RD_READY,               // consumer ready
	input wire logic        O_RD_VALID,               // word valid
	input wire logic        O_SERVO_ENABLE_LINE,      // servo on
	input wire logic        O_ABS_TRANSFER_MODE_LINE, // transfer mode
	input wire logic        O_ABS_REQUEST_LINE,       // request
	input wire logic        O_BUSY,                   // restoring
	input wire logic        O_RANGE_ERR,              // range flag
	input wire logic        O_FEED_REJECT,            // feed flag
	input wire logic [31:0] I_FB_PULSES,              // pulses per revolution
	input wire logic [31:0] I_TARGET_ADDR,            // positioning address
	input wire logic [31:0] I_OUT_PULSES,             // pulses from origin
	input wire logic [31:0] O_RD_DATA                 // position word
);
	default clocking @(posedge I_CORE_CLK); endclocking
	default disable iff (!I_NRST);
	logic [7:0] low_cnt;
	logic       bad;
	longint     lim, p, a;
	assign lim = longint'(I_FB_PULSES) * 32768;
	assign p = longint'($signed(I_OUT_PULSES));
	assign a = longint'($signed(I_TARGET_ADDR));
	assign bad = p < -lim || p >= lim || a < -lim || a >= lim;
	always @(posedge I_CORE_CLK) low_cnt <= (!I_NRST || O_SERVO_ENABLE_LINE) ? 8'h00 : low_cnt + 8'h01;
	property p_feed; $past(I_NRST) |-> O_FEED_REJECT == $past(I_CONT_FEED); endproperty
	property p_take; $rose(O_BUSY) |-> $past(I_START) && !O_SERVO_ENABLE_LINE; endproperty
	property p_drop; $rose(O_SERVO_ENABLE_LINE) && O_BUSY |-> low_cnt == DROP_CYC + 1; endproperty
	property p_mode; O_ABS_REQUEST_LINE |-> O_ABS_TRANSFER_MODE_LINE && O_BUSY; endproperty
	property p_ack; $rose(I_ABS_DATA_READY_LINE) && O_ABS_REQUEST_LINE |-> ##[1:8] !O_ABS_REQUEST_LINE; endproperty
	property p_range; $past(I_NRST) |-> O_RANGE_ERR == $past(bad); endproperty
	property p_hold; O_RD_VALID && !I_RD_READY |=> O_RD_VALID && $stable(O_RD_DATA); endproperty
	a_feed: assert property (p_feed) else $error("feed flag");
	a_take: assert property (p_take) else $error("start");
	a_drop: assert property (p_drop) else $error("servo off span");
	a_mode: assert property (p_mode) else $error("request");
	a_ack: assert property (p_ack) else $error("no release");
	a_range: assert property (p_range) else $error("range flag");
	a_hold: assert property (p_hold) else $error("word hold");
	c_run: cover property ($fell(O_BUSY));
	c_err: cover property (O_RANGE_ERR);
	c_word: cover property (O_RD_VALID && I_RD_READY);
endmodule
bind aprl_restore_link aprl_restore_link_props #(.DROP_CYC(DROP_CYC)) i_props (.*);

// ==== dv/aprl_servo_model.sv ====
// servo amplifier model sending the position two bits a step
`timescale 1ns/1ps
module aprl_servo_model (
	input  wire logic        i_clk,  // core clock
	input  wire logic        i_mode, // transfer mode
	input  wire logic        i_req,  // request
	input  wire logic [31:0] i_word, // position held on battery
	input  wire logic [3:0]  i_lag,  // extra wait before ready
	output logic             o_lo,   // data bit 0
	output logic             o_hi,   // data bit 1
	output logic             o_rdy   // data ready
);
	int step = 0, cnt = 0;
	initial {o_hi, o_lo, o_rdy} = 3'h0;
	always @(posedge i_clk) begin
		if (!i_mode) begin
			step <= 0;
			cnt <= 0;
			o_rdy <= 1'b0;
		end else if (i_req && !o_rdy) begin
			cnt <= cnt + 1;
			if (cnt == 0) {o_hi, o_lo} <= i_word[2 * step +: 2];
			if (cnt > i_lag) o_rdy <= 1'b1;
		end else if (!i_req && o_rdy) begin
			o_rdy <= 1'b0;
			{o_hi, o_lo} <= ~{o_hi, o_lo}; // stale bits must not look valid
			step <= step + 1;
			cnt <= 0;
		end
	end
endmodule

// ==== dv/aprl_restore_link_test.sv ====
// self-checking bench for the restore link
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fails++; $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module aprl_restore_link_test;
	logic        I_CORE_CLK = 0, I_NRST = 0, I_START = 0, I_CONT_FEED = 0, I_RD_READY = 0;
	logic [31:0] I_FB_PULSES = 32'h0000_2000, I_TARGET_ADDR = 0, I_OUT_PULSES = 0, word = 0;
	logic        I_ABS_DATA_LOW_BIT, I_ABS_DATA_HIGH_BIT, I_ABS_DATA_READY_LINE, O_SERVO_ENABLE_LINE, O_BUSY;
	logic        O_ABS_TRANSFER_MODE_LINE, O_ABS_REQUEST_LINE, O_RESTORED, O_RANGE_ERR, O_FEED_REJECT, O_RD_VALID;
	logic [31:0] O_RD_DATA, exp_w, exp_q[$];
	logic [31:0] pv[5] = '{32'h0FFF_FFFF, 32'h1000_0000, 32'hF000_0000, 32'hEFFF_FFFF, 32'h0000_0000};
	logic [3:0]  lag = 0;
	logic        bad;
	int          fails = 0, checks_done = 0, seed = 55534;
	always #50 I_CORE_CLK = ~I_CORE_CLK;
	aprl_restore_link #(.DROP_CYC(5)) i_dut (.*);
	aprl_servo_model i_srv (.i_clk(I_CORE_CLK), .i_mode(O_ABS_TRANSFER_MODE_LINE), .i_req(O_ABS_REQUEST_LINE),
		.i_word(word), .i_lag(lag), .o_lo(I_ABS_DATA_LOW_BIT), .o_hi(I_ABS_DATA_HIGH_BIT), .o_rdy(I_ABS_DATA_READY_LINE));
	task automatic give_verdict;
		fails += exp_q.size();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	always @(negedge I_CORE_CLK) I_RD_READY <= 1'($random(seed));
	always @(posedge I_CORE_CLK) if (O_RD_VALID === 1'b1 && I_RD_READY === 1'b1) begin
		exp_w = exp_q.size() ? exp_q.pop_front() : 32'hX;
		`CHK(O_RD_DATA, exp_w)
	end
	// the deviation clear at the origin is taken as done before every start
	task automatic restore(input logic ok);
		@(negedge I_CORE_CLK);
		word = $random(seed);
		lag = 4'($random(seed));
		I_START = 1;
		@(negedge I_CORE_CLK);
		I_START = 0;
		`CHK(O_BUSY, ok)
		`CHK(O_SERVO_ENABLE_LINE, !ok)
		if (ok) begin
			exp_q.push_back(word);
			for (int n = 0; n < 2000 && O_BUSY === 1'b1; n++) @(negedge I_CORE_CLK);
			`CHK({O_BUSY, O_RESTORED}, 2'h1)
		end
	endtask
	initial begin
		repeat (4) @(negedge I_CORE_CLK);
		I_NRST = 1;
		@(negedge I_CORE_CLK);
		`CHK(O_SERVO_ENABLE_LINE, 1'b1)
		for (int i = 0; i < 7; i++) begin
			I_OUT_PULSES = (i < 5) ? pv[i] : $random(seed) & 32'h0FFF_FFFF;
			I_TARGET_ADDR = (i == 4) ? 32'h1000_0000 : 32'h0000_0000;
			I_CONT_FEED = 1'($random(seed));
			bad = i == 1 || i == 3 || i == 4;
			repeat (2) @(negedge I_CORE_CLK);
			`CHK(O_RANGE_ERR, bad)
			`CHK(O_FEED_REJECT, I_CONT_FEED)
			restore(!bad);
		end
		repeat (20) @(negedge I_CORE_CLK);
		give_verdict;
	end
	initial begin
		#3000000;
		fails++;
		give_verdict;
	end
endmodule
